// ==== hdl/lpst_clk_div.sv ====
// Purpose: derives the pixel clock level and its edge enables
// Assumes: div is even and at least 4
// Notes: fall tick launches data, rise tick is the panel sampling edge
module lpst_clk_div (
  input wire logic clock_i,
  input wire logic rst_i,
  lpst_tick_if.divider tick
);
  logic [7:0] count;
  logic level;
  logic [7:0] next_count;
  logic next_level;

  always_comb begin
    next_count = count + 8'h01;
    next_level = level;
    if (count >= (tick.div >> 1) - 8'h01) begin
      next_count = 8'h00;
      next_level = ~level;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count <= 8'h00;
      level <= 1'b0;
    end else begin
      count <= next_count;
      level <= next_level;
    end
  end

  assign tick.level = level;
  assign tick.rise = (next_level != level) && !level;
  assign tick.fall = (next_level != level) && level;

  a_div_toggles: assert property (@(posedge clock_i) disable iff (rst_i)
    (tick.rise || tick.fall) |=> !(tick.rise || tick.fall)) else $error("tick twice in a row");
endmodule // lpst_clk_div

// ==== hdl/lpst_timing_ctrl.sv ====
// Purpose: drives line/frame sync, pixel valid strobe and RGB to a parallel panel
// Assumes: mode_i static; pixel source answers pixel_req_o on the same cycle
// Notes: syncs, strobe and colour change on falling pixel clock, panel samples on rising
//
// Function
// - line sync pulses low at least one pixel clock to start each row.
// - back porch follows line sync; colour invalid and strobe low.
// - strobe high during active area, one pixel per pixel clock.
// - front porch of invalid data precedes the next line sync.
// - frame sync low pulse; vertical phases sequenced in lines.
// - pixel clock 33.2, 9 or 8.3 MHz by mode; the divider gives 125 MHz divided by 4, 14 or 16 instead.
// - 800, 480 or 400 valid pixels per row.
// - line period 1056, 525 or 528 pixel clocks.
// - horizontal back porch 216, 43 or 108 pixel clocks.
// - horizontal front porch 40, 2 or 20 pixel clocks.
// - 480, 272 or 240 active rows per frame.
// - frame period 525, 286 or 262 lines.
// - frame sync lasts one line period.
// - vertical back porch 35, 12 or 20 lines.
// - vertical front porch 10, 2 or 2 lines.
// - strobe only on active rows, low on blanking lines.
// - colour as 8-bit red, green, blue launched with syncs.
// - panel reset low initialises panel, high for operation.
module lpst_timing_ctrl #(
  parameter int unsigned RESET_HOLD_CYC = lpst_pkg::LPST_RESET_HOLD_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire lpst_pkg::lpst_mode_type mode_i,
  input wire logic [7:0] red_i,
  input wire logic [7:0] green_i,
  input wire logic [7:0] blue_i,
  output logic pixel_req_o,
  output logic frame_start_o,
  output logic pixel_clock_in_o,
  output logic line_sync_n_o,
  output logic frame_sync_n_o,
  output logic pixel_valid_strobe_o,
  output logic [7:0] red_o,
  output logic [7:0] green_o,
  output logic [7:0] blue_o,
  output logic panel_reset_n_o
);
  localparam int unsigned W = lpst_pkg::LPST_CNT_W;

  typedef enum logic [1:0] {LPST_SYNC, LPST_BACK, LPST_ACTIVE, LPST_FRONT} lpst_phase_type;

  // ---------------------------------------------------------------
  // mode table and pixel clock
  // ---------------------------------------------------------------
  lpst_pkg::lpst_timing_type tim;
  always_comb begin
    unique case (mode_i)
      lpst_pkg::LPST_MODE_800X480: tim = lpst_pkg::LPST_T_800;
      lpst_pkg::LPST_MODE_480X272: tim = lpst_pkg::LPST_T_480;
      lpst_pkg::LPST_MODE_400X240: tim = lpst_pkg::LPST_T_400;
      default: tim = lpst_pkg::LPST_T_800;
    endcase
  end

  lpst_tick_if tick ();
  assign tick.div = tim.clk_div;

  lpst_clk_div u_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // panel reset hold
  // ---------------------------------------------------------------
  logic [31:0] hold_cnt;
  logic [31:0] next_hold_cnt;
  logic running;
  always_comb begin
    next_hold_cnt = hold_cnt;
    if (!running) begin
      next_hold_cnt = hold_cnt + 32'h0000_0001;
    end
  end
  assign running = (hold_cnt >= 32'(RESET_HOLD_CYC));
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hold_cnt <= 32'h0000_0000;
    end else begin
      hold_cnt <= next_hold_cnt;
    end
  end

  // ---------------------------------------------------------------
  // horizontal and vertical sequencers
  // ---------------------------------------------------------------
  lpst_phase_type hph, next_hph, vph, next_vph;
  logic [W-1:0] hcnt, next_hcnt, vcnt, next_vcnt;
  logic step;
  logic h_last, line_end;
  logic [W-1:0] h_len, v_len;

  assign step = running && tick.fall;

  always_comb begin
    unique case (hph)
      LPST_SYNC: h_len = tim.horiz.sync;
      // back porch counts from the start of the sync pulse
      LPST_BACK: h_len = tim.horiz.back - tim.horiz.sync;
      LPST_ACTIVE: h_len = tim.horiz.active;
      LPST_FRONT: h_len = tim.horiz.front;
    endcase
    unique case (vph)
      LPST_SYNC: v_len = tim.vert.sync;
      LPST_BACK: v_len = tim.vert.back - tim.vert.sync;
      LPST_ACTIVE: v_len = tim.vert.active;
      LPST_FRONT: v_len = tim.vert.front;
    endcase
  end

  assign h_last = (hcnt == h_len - W'(1));
  assign line_end = h_last && (hph == LPST_FRONT);

  always_comb begin
    next_hph = hph;
    next_hcnt = hcnt;
    next_vph = vph;
    next_vcnt = vcnt;
    if (step) begin
      next_hcnt = hcnt + W'(1);
      if (h_last) begin
        next_hcnt = '0;
        unique case (hph)
          LPST_SYNC: next_hph = LPST_BACK;
          LPST_BACK: next_hph = LPST_ACTIVE;
          LPST_ACTIVE: next_hph = LPST_FRONT;
          LPST_FRONT: next_hph = LPST_SYNC;
        endcase
      end
      if (line_end) begin
        next_vcnt = vcnt + W'(1);
        if (vcnt == v_len - W'(1)) begin
          next_vcnt = '0;
          unique case (vph)
            LPST_SYNC: next_vph = LPST_BACK;
            LPST_BACK: next_vph = LPST_ACTIVE;
            LPST_ACTIVE: next_vph = LPST_FRONT;
            LPST_FRONT: next_vph = LPST_SYNC;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hph <= LPST_SYNC;
      vph <= LPST_SYNC;
      hcnt <= '0;
      vcnt <= '0;
    end else begin
      hph <= next_hph;
      vph <= next_vph;
      hcnt <= next_hcnt;
      vcnt <= next_vcnt;
    end
  end

  // ---------------------------------------------------------------
  // output registers; syncs, strobe and colour launched on falling pixel clock, panel reset on any system clock
  // ---------------------------------------------------------------
  logic vis, next_hs, next_vs, next_de;
  logic [7:0] next_r, next_g, next_b;
  logic hs, vs, de, prst;
  logic [7:0] r, g, b;

  // pins show the state being left, so the first step after reset is a sync
  assign vis = (hph == LPST_ACTIVE) && (vph == LPST_ACTIVE);
  assign pixel_req_o = step && vis;
  assign frame_start_o = step && line_end && (vph == LPST_FRONT)
    && (vcnt == v_len - W'(1));

  always_comb begin
    next_hs = hs;
    next_vs = vs;
    next_de = de;
    next_r = r;
    next_g = g;
    next_b = b;
    if (step) begin
      next_hs = (hph != LPST_SYNC);
      next_vs = (vph != LPST_SYNC);
      next_de = vis;
      next_r = vis ? red_i : 8'h00;
      next_g = vis ? green_i : 8'h00;
      next_b = vis ? blue_i : 8'h00;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hs <= 1'b1;
      vs <= 1'b1;
      de <= 1'b0;
      r <= 8'h00;
      g <= 8'h00;
      b <= 8'h00;
      prst <= 1'b0;
    end else begin
      hs <= next_hs;
      vs <= next_vs;
      de <= next_de;
      r <= next_r;
      g <= next_g;
      b <= next_b;
      prst <= running;
    end
  end

  assign pixel_clock_in_o = tick.level;
  assign line_sync_n_o = hs;
  assign frame_sync_n_o = vs;
  assign pixel_valid_strobe_o = de;
  assign red_o = r;
  assign green_o = g;
  assign blue_o = b;
  assign panel_reset_n_o = prst;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_strobe_in_blank: assert property (@(posedge clock_i) disable iff (rst_i)
    (vph != LPST_ACTIVE && $past(vph) != LPST_ACTIVE) |-> !de) else $error("strobe in vblank");
  a_strobe_no_sync: assert property (@(posedge clock_i) disable iff (rst_i)
    de |-> (hs && vs)) else $error("strobe during sync");
  a_sync_after_front: assert property (@(posedge clock_i) disable iff (rst_i)
    (hph == LPST_SYNC && $changed(hph)) |-> $past(hph) == LPST_FRONT)
    else $error("line sync not after front porch");
  a_vsync_on_line: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(vs) |-> $fell(hs)) else $error("frame sync not aligned to line");
  a_reset_idle: assert property (@(posedge clock_i)
    rst_i |=> (hs && vs && !de && !prst)) else $error("bad reset outputs");
  a_panel_reset: assert property (@(posedge clock_i) disable iff (rst_i)
    !running |=> !prst) else $error("panel released early");
  a_data_blank: assert property (@(posedge clock_i) disable iff (rst_i)
    !de |-> (r == 8'h00 && g == 8'h00 && b == 8'h00)) else $error("colour outside active");
  a_out_on_fall: assert property (@(posedge clock_i) disable iff (rst_i)
    $changed(de) |-> $past(tick.fall)) else $error("strobe moved off falling edge");
  a_hcnt_range: assert property (@(posedge clock_i) disable iff (rst_i)
    hcnt < h_len) else $error("line counter overrun");
  a_vcnt_range: assert property (@(posedge clock_i) disable iff (rst_i)
    vcnt < v_len) else $error("frame counter overrun");

  c_line_sync: cover property (@(posedge clock_i) disable iff (rst_i) $fell(hs));
  c_frame_sync: cover property (@(posedge clock_i) disable iff (rst_i) $fell(vs));
  c_first_pixel: cover property (@(posedge clock_i) disable iff (rst_i) $rose(de));
  c_panel_up: cover property (@(posedge clock_i) disable iff (rst_i) $rose(prst));
endmodule // lpst_timing_ctrl

// ==== inc/lpst_pkg.sv ====
// Purpose: constants and types shared by the panel sync timing controller
// Assumes: 125 MHz system clock
// Notes: horizontal counts in pixel clocks, vertical counts in lines
package lpst_pkg;

  localparam int unsigned LPST_SYS_CLK_KHZ = 125000;
  localparam int unsigned LPST_CNT_W = 12;
  localparam int unsigned LPST_COLOUR_W = 8;
  localparam int unsigned LPST_RESET_HOLD_US = 10;
  localparam int unsigned LPST_RESET_HOLD_CYC =
    (LPST_RESET_HOLD_US * LPST_SYS_CLK_KHZ + 999) / 1000;

  typedef enum logic [1:0] {
    LPST_MODE_800X480,
    LPST_MODE_480X272,
    LPST_MODE_400X240
  } lpst_mode_type;

  typedef struct packed {
    logic [LPST_CNT_W-1:0] sync;
    logic [LPST_CNT_W-1:0] back;
    logic [LPST_CNT_W-1:0] active;
    logic [LPST_CNT_W-1:0] front;
  } lpst_axis_type;

  typedef struct packed {
    lpst_axis_type horiz;
    lpst_axis_type vert;
    logic [7:0] clk_div;
  } lpst_timing_type;

  // pixel clock targets in kHz: 33.2 MHz, 9 MHz, 8.3 MHz
  localparam int unsigned LPST_PCLK_800_KHZ = 33200;
  localparam int unsigned LPST_PCLK_480_KHZ = 9000;
  localparam int unsigned LPST_PCLK_400_KHZ = 8300;
  // divide ratio rounded to nearest, kept even so the clock stays square
  localparam logic [7:0] LPST_DIV_800 =
    8'((LPST_SYS_CLK_KHZ + LPST_PCLK_800_KHZ) / (2 * LPST_PCLK_800_KHZ) * 2);
  localparam logic [7:0] LPST_DIV_480 =
    8'((LPST_SYS_CLK_KHZ + LPST_PCLK_480_KHZ) / (2 * LPST_PCLK_480_KHZ) * 2);
  localparam logic [7:0] LPST_DIV_400 =
    8'((LPST_SYS_CLK_KHZ + LPST_PCLK_400_KHZ) / (2 * LPST_PCLK_400_KHZ) * 2);

  localparam lpst_timing_type LPST_T_800 = '{
    horiz: '{sync: 12'h001, back: 12'h0D8, active: 12'h320, front: 12'h028},
    vert: '{sync: 12'h001, back: 12'h023, active: 12'h1E0, front: 12'h00A},
    clk_div: LPST_DIV_800};
  localparam lpst_timing_type LPST_T_480 = '{
    horiz: '{sync: 12'h001, back: 12'h02B, active: 12'h1E0, front: 12'h002},
    vert: '{sync: 12'h001, back: 12'h00C, active: 12'h110, front: 12'h002},
    clk_div: LPST_DIV_480};
  localparam lpst_timing_type LPST_T_400 = '{
    horiz: '{sync: 12'h001, back: 12'h06C, active: 12'h190, front: 12'h014},
    vert: '{sync: 12'h001, back: 12'h014, active: 12'h0F0, front: 12'h002},
    clk_div: LPST_DIV_400};

endpackage

// ==== inc/lpst_tick_if.sv ====
// Purpose: carries the pixel rate ticks from divider to timing core
// Assumes: single 125 MHz domain
// Notes: rise and fall are one-cycle enables
interface lpst_tick_if;
  logic [7:0] div;
  logic rise;
  logic fall;
  logic level;
  modport divider (input div, output rise, output fall, output level);
  modport core (output div, input rise, input fall, input level);
endinterface

// ==== tb/lpst_panel_model.sv ====
// Purpose: behavioural panel that samples syncs, strobe and colour on the pixel clock
// Assumes: the panel samples on the rising pixel clock
// Notes: the bench reads the measured figures and the pixel queue
module lpst_panel_model (
  input wire logic pixel_clock_in_i,
  input wire logic line_sync_n_i,
  input wire logic frame_sync_n_i,
  input wire logic pixel_valid_strobe_i,
  input wire logic [7:0] red_i,
  input wire logic [7:0] green_i,
  input wire logic [7:0] blue_i,
  input wire logic panel_reset_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int p, lines, row, first_row, line_total, bp, act, act_last, fp, last_v;
  int hs_w, hs_cnt, vs_w, vs_cnt;
  logic hs_prev, vs_prev, v_prev;
  logic [23:0] pix_q[$];
  // ----------------------------------------
  // sampling
  // ----------------------------------------
  always @(posedge pixel_clock_in_i or negedge panel_reset_n_i) begin
    if (!panel_reset_n_i) begin
      p = 0;
      lines = 0;
      row = 0;
      first_row = -1;
      hs_cnt = 0;
      vs_cnt = 0;
      hs_prev = 1'b1;
      vs_prev = 1'b1;
      v_prev = 1'b0;
      pix_q.delete();
    end else begin
      p = p + 1;
      if (!line_sync_n_i && hs_prev) begin
        line_total = p;
        fp = p - last_v - 1;
        p = 0;
        lines = lines + 1;
        row = row + 1;
        if (!frame_sync_n_i && vs_prev) begin
          row = 0;
          first_row = -1;
        end
      end
      if (!line_sync_n_i) hs_cnt = hs_cnt + 1;
      else if (!hs_prev) begin
        hs_w = hs_cnt;
        hs_cnt = 0;
      end
      if (!frame_sync_n_i) vs_cnt = vs_cnt + 1;
      else if (!vs_prev) begin
        vs_w = vs_cnt;
        vs_cnt = 0;
      end
      // colour outside the strobe is ignored
      if (pixel_valid_strobe_i) begin
        if (!v_prev) begin
          bp = p;
          act = 0;
          if (first_row < 0) first_row = row;
        end
        act = act + 1;
        last_v = p;
        pix_q.push_back({red_i, green_i, blue_i});
      end else if (v_prev) act_last = act;
      hs_prev = line_sync_n_i;
      vs_prev = frame_sync_n_i;
      v_prev = pixel_valid_strobe_i;
    end
  end
endmodule // lpst_panel_model

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the panel sync timing controller
// Assumes: inputs driven on the falling system clock edge
// Notes: full frames are too long to run; line timing and the first active row are checked
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 4;
  localparam int LT[3] = '{1056, 525, 528};
  localparam int DIV[3] = '{4, 14, 16};
  logic clock_i, rst_i, pclk, pclk_d, hs_n, vs_n, strobe, preq, prst_n, fs;
  lpst_pkg::lpst_mode_type mode;
  logic [7:0] red, green, blue, r_o, g_o, b_o;
  logic [31:0] rnd;
  logic [23:0] exp_q[$];
  logic [23:0] a, b;
  int bad_count, n_tests, cyc, last_rise, pclk_per, fs_cnt;
  lpst_timing_ctrl #(.RESET_HOLD_CYC(HOLD)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .mode_i(mode), .red_i(red), .green_i(green), .blue_i(blue), .pixel_req_o(preq),
    .frame_start_o(fs), .pixel_clock_in_o(pclk), .line_sync_n_o(hs_n),
    .frame_sync_n_o(vs_n), .pixel_valid_strobe_o(strobe), .red_o(r_o), .green_o(g_o),
    .blue_o(b_o), .panel_reset_n_o(prst_n));
  lpst_panel_model panel (.pixel_clock_in_i(pclk), .line_sync_n_i(hs_n),
    .frame_sync_n_i(vs_n), .pixel_valid_strobe_i(strobe), .red_i(r_o), .green_i(g_o),
    .blue_i(b_o), .panel_reset_n_i(prst_n));
  // ----------------------------------------
  // stimulus and reference model
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // colour for the next edge, queued when the controller consumes it
  always @(negedge clock_i) begin
    cyc = cyc + 1;
    rnd = lfsr(rnd);
    red = rnd[7:0];
    green = rnd[15:8];
    blue = rnd[23:16];
    if (!rst_i && preq === 1'b1) exp_q.push_back({red, green, blue});
    if (!rst_i && fs === 1'b1) fs_cnt++;
    if (pclk === 1'b1 && pclk_d === 1'b0) begin
      pclk_per = cyc - last_rise;
      last_rise = cyc;
    end
    pclk_d = pclk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_lines(input int n);
    int k;
    k = 0;
    while (panel.lines < n && k < 200000) begin
      @(negedge clock_i);
      k++;
    end
    check("line wait", 32'(panel.lines >= n), 1);
  endtask
  task automatic start_mode(input int m);
    int k;
    @(negedge clock_i);
    rst_i = 1'b1;
    mode = lpst_pkg::lpst_mode_type'(m);
    repeat (16) @(negedge clock_i);
    check("reset outputs", {hs_n, vs_n, strobe, prst_n}, 4'b1100);
    exp_q.delete();
    rst_i = 1'b0;
    k = 0;
    while (prst_n !== 1'b1 && k < 50) begin
      @(negedge clock_i);
      k++;
    end
    check("panel release", 32'(k >= 1 && k <= HOLD + 2), 1);
    wait_lines(2);
    check("line period", panel.line_total, LT[m]);
    check("line sync width", panel.hs_w, 1);
    check("frame sync width", panel.vs_w, LT[m]);
    check("pixel clock period", pclk_per, DIV[m]);
    $display("test mode %0d done", m);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    mode = lpst_pkg::LPST_MODE_480X272;
    rnd = 32'h0000_589c;
    red = 8'h00;
    green = 8'h00;
    blue = 8'h00;
    pclk_d = 1'b0;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    last_rise = 0;
    pclk_per = 0;
    fs_cnt = 0;
    start_mode(1);
    wait_lines(14);
    check("back porch", panel.bp, 43);
    check("active pixels", panel.act_last, 480);
    check("front porch", panel.fp, 2);
    check("first active row", panel.first_row, 12);
    check("pixel count", panel.pix_q.size(), exp_q.size());
    while (panel.pix_q.size() > 0 && exp_q.size() > 0) begin
      a = panel.pix_q.pop_front();
      b = exp_q.pop_front();
      check("pixel colour", a, b);
    end
    $display("test pixel stream done");
    start_mode(0);
    start_mode(2);
    check("frame start", fs_cnt, 0);
    test_done();
  end
  initial begin
    #1500000;
    bad_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule // testbench
